/* File: logic/ebcs_bus_front.sv */
`timescale 1ns/1ns
`default_nettype none
module ebcs_bus_front
	import ebcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [31:0] reqAddr,
	input wire logic reqWrite,
	input wire logic [15:0] reqWdata,
	output logic rspValid,
	output logic [15:0] rspRdata,
	output logic rspError,
	output logic [19:0] extAddrOut,
	input wire logic [19:0] extAddrIn,
	output logic [19:0] extAddrOe,
	output logic [7:0] extDataOut,
	input wire logic [7:0] extDataIn,
	output logic [7:0] extDataOe,
	output logic extSelectN,
	output logic extLatchOrSelect1,
	output logic extReadEnableN,
	output logic extDirection
);
	// ========================================
	// Helpers
	function automatic logic winHit(input logic [31:0] a, input logic [31:0] base, input logic [31:0] msk);
		winHit = (((a[31:16] ^ base[31:16]) & ~msk[31:16]) == 16'h0000);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s,
		input logic [31:0] wm);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		merge = ((old & ~m) | (d & m)) & wm;
	endfunction

	// ========================================
	// Register storage and bus slave
	logic [31:0] base0_r, mask0_r, ctrl0_r, base1_r, mask1_r, ctrl1_r, config_r;
	logic awHeld_r, wHeld_r;
	logic [7:0] awAddr_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic doWrite;
	logic wrMapped;
	ebcs_state_t state_r;
	logic [1:0] selPin_r;
	logic lastError_r;
	logic [31:0] statusWord;

	assign awready = !awHeld_r && !bvalid;
	assign wready = !wHeld_r && !bvalid;
	assign arready = !rvalid;
	assign doWrite = awHeld_r && wHeld_r;
	assign wrMapped = (awAddr_r <= OFS_STATUS) && (awAddr_r[1:0] == 2'h0);
	assign statusWord = {28'h0, lastError_r, selPin_r, (state_r != ST_IDLE)};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= awaddr;
			end else if (doWrite) begin
				awHeld_r <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld_r <= 1'b1;
				wData_r <= wdata;
				wStrb_r <= wstrb;
			end else if (doWrite) begin
				wHeld_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			base0_r <= RST_BASE;
			mask0_r <= RST_MASK;
			ctrl0_r <= RST_CTRL;
			base1_r <= RST_BASE;
			mask1_r <= RST_MASK;
			ctrl1_r <= RST_CTRL;
			config_r <= RST_CONFIG;
		end else if (doWrite) begin
			case (awAddr_r)
				OFS_BASE0: base0_r <= merge(base0_r, wData_r, wStrb_r, BASE_WMASK);
				OFS_MASK0: mask0_r <= merge(mask0_r, wData_r, wStrb_r, MASK_WMASK);
				OFS_CTRL0: ctrl0_r <= merge(ctrl0_r, wData_r, wStrb_r, CTRL_WMASK);
				OFS_BASE1: base1_r <= merge(base1_r, wData_r, wStrb_r, BASE_WMASK);
				OFS_MASK1: mask1_r <= merge(mask1_r, wData_r, wStrb_r, MASK_WMASK);
				OFS_CTRL1: ctrl1_r <= merge(ctrl1_r, wData_r, wStrb_r, CTRL_WMASK);
				OFS_CONFIG: config_r <= merge(config_r, wData_r, wStrb_r, CONFIG_WMASK);
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				OFS_BASE0: rdata <= base0_r;
				OFS_MASK0: rdata <= mask0_r;
				OFS_CTRL0: rdata <= ctrl0_r;
				OFS_BASE1: rdata <= base1_r;
				OFS_MASK1: rdata <= mask1_r;
				OFS_CTRL1: rdata <= ctrl1_r;
				OFS_CONFIG: rdata <= config_r;
				OFS_STATUS: rdata <= statusWord;
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ========================================
	// Window decode
	ebcs_mode_t mode;
	logic cs1PinSel, globalOn, inRegion, hit0, hit1, wpBlock, startOk;
	logic [1:0] selNxt;

	assign mode = ebcs_mode_t'(config_r[1:0]);
	assign cs1PinSel = config_r[CFG_CS1_PIN_BIT];
	assign globalOn = mask0_r[MSK_VALID_BIT];
	assign inRegion = (reqAddr[31:22] == REGION_TAG);
	assign hit0 = globalOn && inRegion && winHit(reqAddr, base0_r, mask0_r);
	// Select 1 only exists in non-multiplexed mode with its pin configured
	assign hit1 = globalOn && mask1_r[MSK_VALID_BIT] && inRegion && (mode == MODE_NONMUX8) && cs1PinSel &&
		winHit(reqAddr, base1_r, mask1_r);
	assign selNxt = hit0 ? 2'h1 : (hit1 ? 2'h2 : 2'h0);
	assign wpBlock = reqWrite && (hit0 ? mask0_r[MSK_WP_BIT] : mask1_r[MSK_WP_BIT]);
	assign startOk = (selNxt != 2'h0) && !wpBlock;

	// ========================================
	// Cycle sequencer
	logic [2:0] cnt_r, cntNxt;
	ebcs_state_t stateNxt;
	logic [31:0] curAddr_r;
	logic curWrite_r;
	logic [15:0] curWdata_r;
	ebcs_mode_t curMode_r;
	logic curCs1Pin_r;
	logic [1:0] curSel_r;
	logic accept;

	assign reqReady = (state_r == ST_IDLE);
	assign accept = reqValid && reqReady;

	always_comb begin
		stateNxt = state_r;
		cntNxt = cnt_r;
		case (state_r)
			ST_IDLE: if (accept && startOk) begin
				stateNxt = ST_ADDR;
			end
			ST_ADDR: begin
				stateNxt = ST_DATA;
				cntNxt = DATA_PHASE_CYCLES - 3'h1;
			end
			ST_DATA: if (cnt_r == 3'h0) begin
				stateNxt = ST_DONE;
			end else begin
				cntNxt = cnt_r - 3'h1;
			end
			ST_DONE: stateNxt = ST_IDLE;
			default: stateNxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			cnt_r <= 3'h0;
		end else begin
			state_r <= stateNxt;
			cnt_r <= cntNxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			curAddr_r <= 32'h0000_0000;
			curWrite_r <= 1'b0;
			curWdata_r <= 16'h0000;
			curMode_r <= MODE_NONMUX8;
			curCs1Pin_r <= 1'b0;
			curSel_r <= 2'h0;
		end else if (accept) begin
			curAddr_r <= reqAddr;
			curWrite_r <= reqWrite;
			curWdata_r <= reqWdata;
			curMode_r <= mode;
			curCs1Pin_r <= cs1PinSel;
			curSel_r <= startOk ? selNxt : 2'h0;
		end
	end

	// ========================================
	// Pin drive, registered one cycle behind the sequencer
	logic busy, ale_r, pinSel1;
	logic [19:0] addrOutNxt, addrOeNxt;
	logic [7:0] dataOutNxt, dataOeNxt;

	assign busy = (state_r == ST_ADDR) || (state_r == ST_DATA);

	always_comb begin
		addrOutNxt = 20'h00000;
		addrOeNxt = 20'h00000;
		dataOutNxt = 8'h00;
		dataOeNxt = 8'h00;
		if (busy) begin
			addrOutNxt = curAddr_r[19:0];
			addrOeNxt = 20'hfffff;
			if (state_r == ST_DATA && curMode_r == MODE_MUX16) begin
				addrOutNxt[15:0] = curWdata_r;
				addrOeNxt[15:0] = {16{curWrite_r}};
			end else if (state_r == ST_DATA && curMode_r != MODE_NONMUX8) begin
				addrOutNxt[7:0] = curWdata_r[7:0];
				addrOeNxt[7:0] = {8{curWrite_r}};
			end
			if (curMode_r == MODE_NONMUX8 && curWrite_r) begin
				dataOutNxt = curWdata_r[7:0];
				dataOeNxt = 8'hff;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			extAddrOut <= 20'h00000;
			extAddrOe <= 20'h00000;
			extDataOut <= 8'h00;
			extDataOe <= 8'h00;
		end else begin
			extAddrOut <= addrOutNxt;
			extAddrOe <= addrOeNxt;
			extDataOut <= dataOutNxt;
			extDataOe <= dataOeNxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			selPin_r <= 2'h0;
			ale_r <= 1'b0;
			extReadEnableN <= 1'b1;
			extDirection <= 1'b1;
		end else begin
			selPin_r <= busy ? curSel_r : 2'h0;
			ale_r <= (state_r == ST_ADDR);
			extReadEnableN <= !((state_r == ST_DATA) && !curWrite_r && (curSel_r != 2'h0));
			extDirection <= busy ? !curWrite_r : 1'b1;
		end
	end

	assign extSelectN = !selPin_r[0];
	// Shared pin shows select 1 only when configured so, otherwise the strobe; idle follows the live setting
	assign pinSel1 = reqReady ? (mode == MODE_NONMUX8 && cs1PinSel) : (curMode_r == MODE_NONMUX8 && curCs1Pin_r);
	assign extLatchOrSelect1 = pinSel1 ? !selPin_r[1] : ale_r;

	// ========================================
	// Read capture and response
	logic [27:0] pinsSync;

	ebcs_sync #(
		.WIDTH(28)
	) ebcs_sync_i (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.asyncIn({extDataIn, extAddrIn}),
		.syncOut(pinsSync)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspRdata <= 16'h0000;
			rspError <= 1'b0;
			lastError_r <= 1'b0;
		end else begin
			rspValid <= 1'b0;
			if (accept && !startOk) begin
				rspValid <= 1'b1;
				rspError <= 1'b1;
				rspRdata <= 16'h0000;
				lastError_r <= 1'b1;
			end else if (state_r == ST_DONE) begin
				rspValid <= 1'b1;
				rspError <= 1'b0;
				lastError_r <= 1'b0;
				if (curWrite_r) begin
					rspRdata <= 16'h0000;
				end else if (curMode_r == MODE_NONMUX8) begin
					rspRdata <= {8'h00, pinsSync[27:20]};
				end else if (curMode_r == MODE_MUX16) begin
					rspRdata <= pinsSync[15:0];
				end else begin
					rspRdata <= {8'h00, pinsSync[7:0]};
				end
			end
		end
	end

	// ========================================
	// Checks
	a_ale_single: assert property (@(posedge sys_clk) disable iff (!rst_n) $rose(ale_r) |=> !ale_r)
		else $error("latch strobe longer than one clock");
	a_read_dir: assert property (@(posedge sys_clk) disable iff (!rst_n) !extReadEnableN |-> extDirection)
		else $error("read enable during write direction");
	a_oe_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!extReadEnableN |-> (selPin_r != 2'h0) && !curWrite_r)
		else $error("read enable without read select");
	a_mux_data_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(curMode_r != MODE_NONMUX8) |-> (extDataOe == 8'h00))
		else $error("data pins driven in multiplexed mode");
	a_addr_phase: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ale_r |-> (extAddrOut == curAddr_r[19:0]) && (extAddrOe == 20'hfffff))
		else $error("address phase does not show full address");
	a_high_addr_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ale_r ##1 (curMode_r == MODE_MUX16) |-> (extAddrOut[19:16] == curAddr_r[19:16]) && (&extAddrOe[19:16]))
		else $error("upper address lost in data phase");
	a_wp_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
		accept && wpBlock |=> rspValid && rspError && (state_r == ST_IDLE))
		else $error("protected write did not end in error");
	a_no_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
		accept && (selNxt == 2'h0) |=> (state_r == ST_IDLE) ##1 (selPin_r == 2'h0))
		else $error("cycle started without a window");
	a_cs1_mux_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(curMode_r != MODE_NONMUX8) |-> !selPin_r[1])
		else $error("select 1 active in multiplexed mode");
	a_region_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(selPin_r != 2'h0) |-> (curAddr_r[31:22] == REGION_TAG))
		else $error("select outside allowed region");
	a_invalid_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		accept && !globalOn |=> rspError ##1 (selPin_r == 2'h0))
		else $error("select used before enable");
endmodule
`default_nettype wire

/* File: shared/ebcs_pkg.sv */
package ebcs_pkg;
	localparam logic [7:0] OFS_BASE0 = 8'h00;
	localparam logic [7:0] OFS_MASK0 = 8'h04;
	localparam logic [7:0] OFS_CTRL0 = 8'h08;
	localparam logic [7:0] OFS_BASE1 = 8'h0c;
	localparam logic [7:0] OFS_MASK1 = 8'h10;
	localparam logic [7:0] OFS_CTRL1 = 8'h14;
	localparam logic [7:0] OFS_CONFIG = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;

	localparam logic [31:0] RST_BASE = 32'h0000_0000;
	localparam logic [31:0] RST_MASK = 32'h0000_0000;
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_CONFIG = 32'h0000_0000;

	localparam logic [31:0] BASE_WMASK = 32'hffff_0000;
	localparam logic [31:0] MASK_WMASK = 32'hffff_0101;
	localparam logic [31:0] CTRL_WMASK = 32'hffff_ffff;
	localparam logic [31:0] CONFIG_WMASK = 32'h0000_0007;

	localparam int MSK_VALID_BIT = 0;
	localparam int MSK_WP_BIT = 8;
	localparam int CFG_CS1_PIN_BIT = 2;
	localparam logic [9:0] REGION_TAG = 10'h001;

	localparam logic [2:0] DATA_PHASE_CYCLES = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_NONMUX8 = 2'h0,
		MODE_MUX16 = 2'h1,
		MODE_MUX8 = 2'h2
	} ebcs_mode_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ADDR = 2'h1,
		ST_DATA = 2'h3,
		ST_DONE = 2'h2
	} ebcs_state_t;
endpackage

/* File: logic/ebcs_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module ebcs_sync #(
	parameter int WIDTH = 28
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_r;

	// Second stage is the only reader of the first
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			stage1_r <= '0;
			syncOut <= '0;
		end else begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end
endmodule
`default_nettype wire

/* File: tb/ebcs_ext_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module ebcs_ext_mem (
	input wire logic sys_clk,
	input wire logic [19:0] padIn,
	input wire logic latchStb,
	input wire logic readEnableN,
	output logic [19:0] padDrv,
	output logic [7:0] dataDrv
);
	logic [19:0] lat_r = 20'h0;
	logic [15:0] idle_r = 16'h5a5a;
	logic [15:0] val;
	// ==========================================
	// Address capture and read answer
	always_ff @(posedge sys_clk) begin
		idle_r <= ~idle_r;
		if (latchStb) begin
			lat_r <= padIn;
		end
	end
	assign val = lat_r[15:0] ^ 16'ha5c3;
	// Released lines show a pattern that flips every cycle, except pad lines 19:16, which stay 0
	assign padDrv = readEnableN ? {4'h0, idle_r} : {lat_r[19:16], val};
	assign dataDrv = readEnableN ? idle_r[7:0] : val[7:0];
endmodule
`default_nettype wire

/* File: tb/external_bus_chip_select_interface_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module external_bus_chip_select_interface_tb_top
	import ebcs_pkg::*;
;
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic reqValid = 1'h0, reqWrite = 1'h0;
	logic [31:0] wdata = 32'h0, reqAddr = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [15:0] reqWdata = 16'h0;
	logic awready, wready, bvalid, arready, rvalid, reqReady, rspValid, rspError;
	logic extSelectN, extLatchOrSelect1, extReadEnableN, extDirection;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] rspRdata;
	logic [19:0] extAddrOut, extAddrOe, extAddrIn, padDrv, aleAddr, aleOe, dAddr, dAddrOe;
	logic [7:0] extDataOut, extDataOe, extDataIn, dataDrv, dData, dDataOe;
	logic mon = 1'h0, stbMode = 1'h1, curWr = 1'h0, gotD = 1'h0;
	int selCnt, sel1Cnt, oeCnt, aleCnt, dirBad;
	int error_cnt = 0;
	int checks = 0;

	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	ebcs_bus_front ebcs_bus_front_i (.sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .reqValid(reqValid), .reqReady(reqReady),
		.reqAddr(reqAddr), .reqWrite(reqWrite), .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
		.rspError(rspError), .extAddrOut(extAddrOut), .extAddrIn(extAddrIn), .extAddrOe(extAddrOe),
		.extDataOut(extDataOut), .extDataIn(extDataIn), .extDataOe(extDataOe), .extSelectN(extSelectN),
		.extLatchOrSelect1(extLatchOrSelect1), .extReadEnableN(extReadEnableN), .extDirection(extDirection));

	ebcs_ext_mem ebcs_ext_mem_i (.sys_clk(sys_clk), .padIn(extAddrIn), .latchStb(stbMode & extLatchOrSelect1),
		.readEnableN(extReadEnableN), .padDrv(padDrv), .dataDrv(dataDrv));

	assign extAddrIn = (extAddrOe & extAddrOut) | (~extAddrOe & padDrv);
	assign extDataIn = (extDataOe & extDataOut) | (~extDataOe & dataDrv);

	// ==========================================
	// Pin monitor
	always @(negedge sys_clk) begin
		if (mon) begin
			if (aleCnt != 0 && !extLatchOrSelect1 && !extSelectN && !gotD) begin
				gotD = 1'h1;
				dAddr = extAddrOut;
				dAddrOe = extAddrOe;
				dData = extDataOut;
				dDataOe = extDataOe;
			end
			if (!extSelectN) selCnt++;
			if (!extReadEnableN) oeCnt++;
			if (stbMode && extLatchOrSelect1) begin
				aleCnt++;
				aleAddr = extAddrOut;
				aleOe = extAddrOe;
			end
			if (!stbMode && !extLatchOrSelect1) sel1Cnt++;
			if ((!extSelectN || (!stbMode && !extLatchOrSelect1)) && extDirection !== !curWr) dirBad++;
		end
	end

	// ==========================================
	// Checking and closing
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ==========================================
	// Register bus and request port access
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'h0;
		w = 1'h0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw && w)) begin
			@(negedge sys_clk);
			if (awvalid && awready) aw = 1'h1;
			if (wvalid && wready) w = 1'h1;
			@(posedge sys_clk);
			if (aw) awvalid <= 1'h0;
			if (w) wvalid <= 1'h0;
		end
		do @(negedge sys_clk); while (!bvalid);
		chk("bresp", 32'(bresp), 32'(RESP_OKAY));
		@(posedge sys_clk);
		bready <= 1'h0;
	endtask

	task automatic rreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(negedge sys_clk); while (!arready);
		@(posedge sys_clk);
		arvalid <= 1'h0;
		do @(negedge sys_clk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge sys_clk);
		rready <= 1'h0;
	endtask

	task automatic req(input logic [31:0] a, input logic wr, input logic [15:0] wd, input logic expErr);
		selCnt = 0;
		sel1Cnt = 0;
		oeCnt = 0;
		aleCnt = 0;
		dirBad = 0;
		gotD = 1'h0;
		curWr = wr;
		mon = 1'h1;
		@(posedge sys_clk);
		reqAddr <= a;
		reqWrite <= wr;
		reqWdata <= wd;
		reqValid <= 1'h1;
		do @(negedge sys_clk); while (!reqReady);
		@(posedge sys_clk);
		reqValid <= 1'h0;
		do @(negedge sys_clk); while (!rspValid);
		mon = 1'h0;
		chk("rspError", 32'(rspError), 32'(expErr));
	endtask

	initial begin
		repeat (4000) @(posedge sys_clk);
		error_cnt++;
		wrap_up();
	end

	// ==========================================
	// Test sequence
	initial begin
		logic [31:0] d, a, ea;
		logic [1:0] r;
		logic [15:0] e;
		a = 32'h0041_2345;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		for (int i = 0; i < 6; i++) begin
			rreg(8'(i * 4), d, r);
			chk("reset value", d, 32'h0);
		end
		rreg(8'h20, d, r);
		chk("unmapped", 32'(r), 32'(RESP_SLVERR));
		wreg(OFS_BASE0, 32'h0040_0000);
		wreg(OFS_MASK0, 32'h000f_0000);
		rreg(OFS_MASK0, d, r);
		chk("mask readback", d, 32'h000f_0000);
		req(a, 1'h0, 16'h0, 1'h1);
		chk("sel before valid", 32'(selCnt), 32'h0);
		wreg(OFS_MASK0, 32'h000f_0001);
		for (int m = 0; m < 4; m++) begin
			wreg(OFS_CONFIG, 32'(m));
			req(a, 1'h1, 16'hbeef, 1'h0);
			chk("ale count", 32'(aleCnt), 32'h1);
			chk("ale addr", 32'(aleAddr), 32'(a[19:0]));
			chk("ale oe", 32'(aleOe), 32'h000f_ffff);
			chk("dir write", 32'(dirBad), 32'h0);
			chk("oe on write", 32'(oeCnt), 32'h0);
			chk("sel hit", 32'(selCnt != 0), 32'h1);
			ea = (m == 0) ? 32'(a[19:0]) : (m == 1) ? {12'h0, a[19:16], 16'hbeef} : {12'h0, a[19:8], 8'hef};
			chk("data phase pins", 32'(dAddr), ea);
			chk("data phase oe", 32'(dAddrOe), 32'h000f_ffff);
			chk("data pins oe", 32'(dDataOe), (m == 0) ? 32'h0000_00ff : 32'h0);
			if (m == 0) chk("data pins", 32'(dData), 32'h0000_00ef);
			req(a, 1'h0, 16'h0, 1'h0);
			e = a[15:0] ^ 16'ha5c3;
			chk("read data", (m == 1) ? 32'(rspRdata) : 32'(rspRdata[7:0]), (m == 1) ? 32'(e) : 32'(e[7:0]));
			chk("oe on read", 32'(oeCnt != 0), 32'h1);
			chk("dir read", 32'(dirBad), 32'h0);
			chk("ale read", 32'(aleCnt), 32'h1);
		end
		req(32'h0050_0000, 1'h0, 16'h0, 1'h1);
		chk("miss pins", 32'(selCnt + oeCnt + aleCnt), 32'h0);
		wreg(OFS_MASK0, 32'h0008_0001);
		req(32'h0048_0000, 1'h0, 16'h0, 1'h0);
		req(32'h0044_0000, 1'h0, 16'h0, 1'h1);
		wreg(OFS_MASK0, 32'h000f_0101);
		req(a, 1'h1, 16'h1111, 1'h1);
		chk("protected pins", 32'(selCnt + aleCnt), 32'h0);
		rreg(OFS_STATUS, d, r);
		chk("status error flag", d, 32'h0000_0008);
		req(a, 1'h0, 16'h0, 1'h0);
		wreg(OFS_BASE1, 32'h0080_0000);
		wreg(OFS_MASK1, 32'h0000_0001);
		wreg(OFS_CONFIG, 32'h4);
		stbMode = 1'h0;
		req(32'h0080_0000, 1'h1, 16'h0, 1'h1);
		chk("sel1 outside region", 32'(sel1Cnt), 32'h0);
		wreg(OFS_BASE1, 32'h0060_0000);
		req(32'h0060_0010, 1'h1, 16'h1234, 1'h0);
		chk("sel1 hit", 32'(sel1Cnt != 0), 32'h1);
		chk("sel0 idle", 32'(selCnt), 32'h0);
		chk("dir sel1", 32'(dirBad), 32'h0);
		wreg(OFS_CONFIG, 32'h5);
		stbMode = 1'h1;
		req(32'h0060_0010, 1'h1, 16'h1234, 1'h1);
		chk("sel1 in mux", 32'(selCnt), 32'h0);
		chk("strobe idle", 32'(aleCnt), 32'h0);
		wrap_up();
	end
endmodule
`default_nettype wire
